// ---- verilog/cli_defs.svh ----
`ifndef CLI_DEFS_SVH
`define CLI_DEFS_SVH
// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define CLI_OFS_INSTR 8'h00
`define CLI_OFS_DATA 8'h04
`define CLI_OFS_STATE 8'h08
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLI_CLK_MHZ 250
`define CLI_CTRL_NS 39000
`define CLI_DATA_NS 43000
`define CLI_CLEAR_NS 1530000
`define CLI_BLINK_MS 370
`define CLI_NS_CYC(ns) ((((ns) * `CLI_CLK_MHZ) + 999) / 1000)
`define CLI_BLINK_CYC (`CLI_BLINK_MS * 1000 * `CLI_CLK_MHZ)
`define CLI_FW_MUL 32'h0000_0006
`define CLI_FW_DIV 32'h0000_0005
// ---------------------------------------------------------------
// Address ranges and reset values
// ---------------------------------------------------------------
`define CLI_ONE_LAST 7'h4f
`define CLI_TWO_L1_LAST 7'h27
`define CLI_TWO_L2_FIRST 7'h40
`define CLI_TWO_L2_LAST 7'h67
`define CLI_FOUR_LAST 5'h13
`define CLI_FOUR_L2_FIRST 7'h20
`define CLI_SPACE 8'h20
`define CLI_SCROLL_MAX 6'h30
`define CLI_MASK_6DOT 6'h3f
`define CLI_MASK_5DOT 6'h1f
`endif

// ---- verilog/cli_pkg.sv ----
package cli_pkg;
  typedef enum logic [1:0] {CLI_RAM_CHAR, CLI_RAM_GLYPH, CLI_RAM_ICON} cli_ram_e;
  typedef enum logic [1:0] {CLI_LINES_ONE, CLI_LINES_TWO, CLI_LINES_FOUR} cli_lines_e;
endpackage

// ---- verilog/cli_decoder.sv ----
// Operation
// - Display enable lights the panel; clearing it blanks but keeps char RAM.
// - Cursor enable cleared hides cursor; increment setting is kept.
// - Blink alternates cursor cell all-on and character, 370 ms phases.
// - Font width set gives 6-dot characters and 6/5 longer busy times.
// - In 6-dot mode glyph rows use bits 5 down to 0.
// - Cursor invert toggles cursor cell every 370 ms; cursor and blink ignored.
// - Four-line enable selects four-line mode; two-line select is ignored.
// - Shift touches no RAM; cursor shift steps address, display shift moves view.
// - Display shift keeps address counter and moves all lines together.
// - Cursor wraps to next line after digit 40 (two-line) or 20 (four-line).
// - Each of four scroll enables scrolls its own line.
// - Bus width select chooses 8-bit or 4-bit host bus.
// - Two-line select picks one or two lines while four-line is off.
// - Extended select reroutes codes; basic function set clears it.
// - Glyph blink enable blinks glyphs and icons by top two data bits.
// - Address sets load the counter and pick char, glyph or icon RAM.
// - Char RAM ranges: 00-4F one-line; 00-27 and 40-67 two-line.
// - Four-line ranges are 00-13, 20-33, 40-53 and 60-73.
// - Scroll quantity shifts up to 47 dots; top bits both set give 48.
// - Status read returns busy on bit 7 and address below; host waits.
// - Data write stores into selected RAM then steps address by one.
// - First read after no address set is stale; cursor shifts preload read data, display shifts do not.
// - Increment set steps address up; cleared steps it down.
// - Control and address instructions except clear and home keep busy for 39 us.
`timescale 1ns/1ps
`include "cli_defs.svh"
module cli_decoder import cli_pkg::*; #(
  parameter int unsigned CTRL_CYC = `CLI_NS_CYC(`CLI_CTRL_NS),
  parameter int unsigned DATA_CYC = `CLI_NS_CYC(`CLI_DATA_NS),
  parameter int unsigned CLEAR_CYC = `CLI_NS_CYC(`CLI_CLEAR_NS),
  parameter int unsigned BLINK_CYC = `CLI_BLINK_CYC
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // Sync reset, high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Write enable
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  output logic display_on_o, // Panel driven
  output logic cursor_show_o, // Cursor underline shown
  output logic cursor_fill_o, // Cursor cell all-on phase
  output logic cursor_invert_o, // Cursor cell inverted phase
  output logic glyph_blink_o, // Glyph/icon blink phase
  output logic font_width_o, // 6-dot font
  output logic [5:0] glyph_mask_o, // Glyph row bits shown
  output logic bus_width8_o, // 8-bit host bus
  output cli_lines_e line_mode_o, // Line mode
  output logic [6:0] disp_shift_o, // Display shift offset
  output logic [23:0] scroll_dots_o // Per-line dot scroll, 6 bits each
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic ack_q, disp_q, cur_q, blink_q, fw_q, inv_q, four_q, bus8_q, two_q;
  logic ext_q, gblink_q, inc_q, ent_s_q, phase_q;
  logic [3:0] hs_q;
  logic [5:0] qty_q;
  logic [6:0] ac_q, shift_q;
  logic [7:0] ord_q;
  logic [31:0] busy_q, blink_cnt_q;
  cli_ram_e sel_q;
  logic [7:0] ccr_q [128];
  logic [7:0] gly_q [64];
  logic [7:0] ico_q [16];
  cli_lines_e lines;
  logic busy, req, wr, ex_cmd, ex_wr, ex_rd;
  logic [7:0] cmd;
  logic [6:0] ac_step, cur_step;
  logic [31:0] base_cyc;

  function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up,
                                         input cli_ram_e r, input cli_lines_e m);
    logic [6:0] n;
    n = up ? a + 7'd1 : a - 7'd1;
    case (r)
      CLI_RAM_GLYPH: n = {1'b0, n[5:0]};
      CLI_RAM_ICON: n = {3'b000, n[3:0]};
      default: begin
        case (m)
          CLI_LINES_ONE: begin
            if (up && a == `CLI_ONE_LAST) n = 7'h00;
            else if (!up && a == 7'h00) n = `CLI_ONE_LAST;
          end
          CLI_LINES_TWO: begin
            if (up && a == `CLI_TWO_L1_LAST) n = `CLI_TWO_L2_FIRST;
            else if (up && a == `CLI_TWO_L2_LAST) n = 7'h00;
            else if (!up && a == `CLI_TWO_L2_FIRST) n = `CLI_TWO_L1_LAST;
            else if (!up && a == 7'h00) n = `CLI_TWO_L2_LAST;
          end
          default: begin
            if (up && a[4:0] == `CLI_FOUR_LAST) n = {a[6:5] + 2'd1, 5'h00};
            else if (!up && a[4:0] == 5'h00) n = {a[6:5] - 2'd1, `CLI_FOUR_LAST};
          end
        endcase
      end
    endcase
    return n;
  endfunction

  function automatic logic [7:0] ram_at(input cli_ram_e r, input logic [6:0] a);
    case (r)
      CLI_RAM_GLYPH: return gly_q[a[5:0]];
      CLI_RAM_ICON: return ico_q[a[3:0]];
      default: return ccr_q[a];
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign lines = four_q ? CLI_LINES_FOUR : (two_q ? CLI_LINES_TWO : CLI_LINES_ONE);
  assign busy = busy_q != 32'h0000_0000;
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i & sel_i[0];
  assign cmd = dat_i[7:0];
  // Instruction writes and data accesses during busy are acked but dropped; status reads are served; host must poll first
  assign ex_cmd = wr & (adr_i == `CLI_OFS_INSTR) & ~busy;
  assign ex_wr = wr & (adr_i == `CLI_OFS_DATA) & ~busy;
  assign ex_rd = req & ~we_i & (adr_i == `CLI_OFS_DATA) & ~busy;
  assign ac_step = step_ac(ac_q, inc_q, sel_q, lines);
  assign cur_step = step_ac(ac_q, cmd[2], CLI_RAM_CHAR, lines);
  assign ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        case (adr_i)
          `CLI_OFS_INSTR: dat_o <= {24'h00_0000, busy, ac_q};
          `CLI_OFS_DATA: dat_o <= {24'h00_0000, ord_q};
          `CLI_OFS_STATE: dat_o <= {1'b0, sel_q, shift_q, qty_q, hs_q, ent_s_q, inc_q,
                                    gblink_q, ext_q, two_q, bus8_q, four_q, inv_q, fw_q,
                                    blink_q, cur_q, disp_q};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Busy timer
  // ---------------------------------------------------------------
  always_comb begin
    base_cyc = CTRL_CYC;
    if (ex_wr || ex_rd) base_cyc = DATA_CYC;
    else if (cmd[7:2] == 6'h00 && cmd[1:0] != 2'b00) base_cyc = CLEAR_CYC;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= CLEAR_CYC; // Reset runs the clear sequence
    end else if (ex_cmd || ex_wr || ex_rd) begin
      busy_q <= fw_q ? base_cyc * `CLI_FW_MUL / `CLI_FW_DIV : base_cyc;
    end else if (busy) begin
      busy_q <= busy_q - 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Instruction execution
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {disp_q, cur_q, blink_q, fw_q, inv_q, four_q, ext_q, gblink_q, ent_s_q} <= 9'h000;
      {bus8_q, two_q, inc_q} <= 3'b111;
      hs_q <= 4'h0;
      qty_q <= 6'h00;
      ac_q <= 7'h00;
      shift_q <= 7'h00;
      ord_q <= 8'h00;
      sel_q <= CLI_RAM_CHAR;
      for (int i = 0; i < 128; i++) ccr_q[i] <= `CLI_SPACE;
      for (int i = 0; i < 64; i++) gly_q[i] <= 8'h00;
      for (int i = 0; i < 16; i++) ico_q[i] <= 8'h00;
    end else if (ex_cmd) begin
      casez (cmd)
        8'b1???????: begin
          if (ext_q) qty_q <= cmd[5:0];
          else begin
            ac_q <= cmd[6:0];
            sel_q <= CLI_RAM_CHAR;
            ord_q <= ccr_q[cmd[6:0]];
          end
        end
        8'b01??????: begin
          if (ext_q) begin
            ac_q <= {3'b000, cmd[3:0]};
            sel_q <= CLI_RAM_ICON;
            ord_q <= ico_q[cmd[3:0]];
          end else begin
            ac_q <= {1'b0, cmd[5:0]};
            sel_q <= CLI_RAM_GLYPH;
            ord_q <= gly_q[cmd[5:0]];
          end
        end
        8'b001?????: begin
          bus8_q <= cmd[4];
          two_q <= cmd[3];
          ext_q <= cmd[2];
          if (cmd[2]) gblink_q <= cmd[1];
        end
        8'b0001????: begin
          if (ext_q) hs_q <= cmd[3:0];
          else if (cmd[3]) shift_q <= cmd[2] ? shift_q + 7'd1 : shift_q - 7'd1;
          else begin
            ac_q <= cur_step;
            ord_q <= ccr_q[cur_step];
          end
        end
        8'b00001???: begin
          if (ext_q) {fw_q, inv_q, four_q} <= cmd[2:0];
          else {disp_q, cur_q, blink_q} <= cmd[2:0];
        end
        8'b000001??: {inc_q, ent_s_q} <= cmd[1:0];
        8'b0000001?: begin
          ac_q <= 7'h00;
          sel_q <= CLI_RAM_CHAR;
          shift_q <= 7'h00;
        end
        8'b00000001: begin
          for (int i = 0; i < 128; i++) ccr_q[i] <= `CLI_SPACE;
          ac_q <= 7'h00;
          sel_q <= CLI_RAM_CHAR;
          shift_q <= 7'h00;
          inc_q <= 1'b1;
        end
        default: ;
      endcase
    end else if (ex_wr) begin
      case (sel_q)
        CLI_RAM_GLYPH: gly_q[ac_q[5:0]] <= dat_i[7:0];
        CLI_RAM_ICON: ico_q[ac_q[3:0]] <= dat_i[7:0];
        default: begin
          ccr_q[ac_q] <= dat_i[7:0];
          if (ent_s_q) shift_q <= inc_q ? shift_q - 7'd1 : shift_q + 7'd1;
        end
      endcase
      ac_q <= ac_step;
    end else if (ex_rd) begin
      ac_q <= ac_step;
      ord_q <= ram_at(sel_q, ac_step);
    end
  end

  // ---------------------------------------------------------------
  // Blink timer and display outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_CYC - 32'h0000_0001) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q <= ~phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {display_on_o, cursor_show_o, cursor_fill_o, cursor_invert_o} <= 4'h0;
      {glyph_blink_o, font_width_o, bus_width8_o} <= 3'b001;
      glyph_mask_o <= `CLI_MASK_5DOT;
      line_mode_o <= CLI_LINES_TWO;
      disp_shift_o <= 7'h00;
      scroll_dots_o <= 24'h00_0000;
    end else begin
      display_on_o <= disp_q;
      cursor_show_o <= disp_q & ~inv_q & cur_q;
      cursor_fill_o <= disp_q & ~inv_q & blink_q & phase_q;
      cursor_invert_o <= disp_q & inv_q & phase_q;
      glyph_blink_o <= gblink_q & phase_q;
      font_width_o <= fw_q;
      glyph_mask_o <= fw_q ? `CLI_MASK_6DOT : `CLI_MASK_5DOT;
      bus_width8_o <= bus8_q;
      line_mode_o <= lines;
      disp_shift_o <= shift_q;
      for (int i = 0; i < 4; i++) begin
        scroll_dots_o[i*6 +: 6] <= !hs_q[i] ? 6'h00 :
                                   (qty_q[5:4] == 2'b11 ? `CLI_SCROLL_MAX : qty_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  busy_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_cmd && cmd[7:2] != 6'h00 && !fw_q |=> busy_q == CTRL_CYC)
    else $error("control busy time wrong");
  busy_scale_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && fw_q |=> busy_q == DATA_CYC * `CLI_FW_MUL / `CLI_FW_DIV)
    else $error("6-dot busy scaling wrong");
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_i == `CLI_OFS_INSTR |=> dat_o[7:0] == {$past(busy), $past(ac_q)})
    else $error("status read mismatch");
  disp_shift_ac_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_cmd && !ext_q && cmd[7:3] == 5'b00011 |=> $stable(ac_q))
    else $error("display shift moved address");
  cursor_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_cmd && !ext_q && cmd[7:3] == 5'b00010 |=> ac_q == $past(cur_step))
    else $error("cursor shift step wrong");
  scroll_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hs_q[0] && qty_q[5:4] == 2'b11 |=> scroll_dots_o[5:0] == `CLI_SCROLL_MAX)
    else $error("scroll not 48 dots");
  invert_hides_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inv_q ##1 inv_q |-> !cursor_show_o && !cursor_fill_o)
    else $error("cursor shown in invert mode");
  basic_fset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_cmd && cmd[7:5] == 3'b001 && !cmd[2] |=> !ext_q)
    else $error("basic function set kept extended");
  glyph_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && sel_q == CLI_RAM_GLYPH && inc_q |=> ac_q[5:0] == $past(ac_q[5:0]) + 6'd1)
    else $error("glyph write step wrong");
  read_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_rd |=> ac_q == $past(ac_step) ##1 busy)
    else $error("read did not step address");
  // Outputs are registered, so output checks look one clock after the state
  display_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !disp_q |=> !display_on_o && !cursor_show_o && !cursor_fill_o && !cursor_invert_o)
    else $error("display off still lights panel");
  cursor_hide_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cur_q |=> !cursor_show_o)
    else $error("cursor shown while disabled");
  inc_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_cmd && !ext_q && cmd[7:3] == 5'b00001 |=> inc_q == $past(inc_q))
    else $error("display control changed increment");
  fill_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
    disp_q && !inv_q && blink_q && phase_q |=> cursor_fill_o)
    else $error("blink all-on phase missing");
  mask_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fw_q |=> glyph_mask_o == `CLI_MASK_6DOT)
    else $error("6-dot glyph mask wrong");
  four_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
    four_q |=> line_mode_o == CLI_LINES_FOUR)
    else $error("four-line mode not shown");
  line_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !four_q && !two_q |=> line_mode_o == CLI_LINES_ONE)
    else $error("one-line mode not shown");
  busy_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && busy && adr_i == `CLI_OFS_DATA |=> $stable(ac_q))
    else $error("data write taken while busy");
  scroll_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !hs_q[1] |=> scroll_dots_o[11:6] == 6'h00)
    else $error("disabled line scrolled");
  wrap_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && sel_q == CLI_RAM_CHAR && lines == CLI_LINES_ONE && inc_q &&
    ac_q == `CLI_ONE_LAST |=> ac_q == 7'h00)
    else $error("one-line wrap wrong");
  wrap_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && sel_q == CLI_RAM_CHAR && lines == CLI_LINES_TWO && inc_q &&
    ac_q == `CLI_TWO_L1_LAST |=> ac_q == `CLI_TWO_L2_FIRST)
    else $error("two-line wrap wrong");
  wrap_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && sel_q == CLI_RAM_CHAR && lines == CLI_LINES_FOUR && inc_q &&
    ac_q == {2'b00, `CLI_FOUR_LAST} |=> ac_q == `CLI_FOUR_L2_FIRST)
    else $error("four-line wrap wrong");
  glyph_blink_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !gblink_q |=> !glyph_blink_o)
    else $error("glyph blink while disabled");
  icon_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_wr && sel_q == CLI_RAM_ICON && inc_q |=> ac_q[3:0] == $past(ac_q[3:0]) + 4'd1)
    else $error("icon write step wrong");
endmodule // cli_decoder

// ---- testbench/cli_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Microprocessor side as a Wishbone classic master
// ---------------------------------------------------------------
module cli_host_model (
  input wire logic clk_i, // Clock
  input wire logic ack_i, // Acknowledge
  input wire logic [31:0] dat_i, // Read data
  output logic cyc_o, // Cycle
  output logic stb_o, // Strobe
  output logic we_o, // Write enable
  output logic [7:0] adr_o, // Address
  output logic [3:0] sel_o, // Byte selects
  output logic [31:0] dat_o // Write data
);
  logic [31:0] rd_q;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    rd_q = '0;
  end
  // Request held until ack is sampled; a lost ack ends the run
  task automatic cycle(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) break;
    end
    rd_q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
    if (n == 40) tb.timed_out();
  endtask
  // No new instruction until the busy bit reads low
  task automatic ready();
    int k;
    for (k = 0; k < 40; k++) begin
      tb.note(32'h0, 32'h0);
      cycle(1'b0, 8'h00, 4'h1, 32'h0);
      if (rd_q[7] === 1'b0) break;
    end
    if (k == 40) tb.timed_out();
  endtask
endmodule // cli_host_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, disp, cshow, cfill, cinv, gblink, fw, bus8;
  logic [7:0] adr, r1, r2, g;
  logic [3:0] sel, hs;
  logic [31:0] wdat, rdat;
  logic [5:0] gmask, sq, hl;
  cli_pkg::cli_lines_e lmode;
  logic [6:0] dshift;
  logic [23:0] sdots;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [5:0] sq_t [5] = '{6'h00, 6'h01, 6'h2f, 6'h30, 6'h3f};
  int bad_count = 0;
  int num_checks = 0;
  int i;
  always #2 clk_i = ~clk_i;
  cli_decoder #(.CTRL_CYC(8), .DATA_CYC(10), .CLEAR_CYC(20), .BLINK_CYC(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .display_on_o(disp),
    .cursor_show_o(cshow), .cursor_fill_o(cfill), .cursor_invert_o(cinv),
    .glyph_blink_o(gblink), .font_width_o(fw), .glyph_mask_o(gmask), .bus_width8_o(bus8),
    .line_mode_o(lmode), .disp_shift_o(dshift), .scroll_dots_o(sdots));
  cli_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // ---------------------------------------------------------------
  // Scoreboard
  // ---------------------------------------------------------------
  task automatic note(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
  endtask
  always @(posedge clk_i) begin : mon
    logic [31:0] e;
    logic [31:0] m;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) `CHK(rdat & m, e)
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic timed_out();
    bad_count++;
    results();
  endtask
  // ---------------------------------------------------------------
  // Bus helpers
  // ---------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note(e, m);
    host.cycle(1'b0, a, 4'h1, 32'h0);
  endtask
  task automatic instr(input logic [7:0] c);
    host.cycle(1'b1, 8'h00, 4'h1, {24'h0, c});
    rd(8'h00, 32'h80, 32'h80);
    host.ready();
  endtask
  task automatic dw(input logic [7:0] d);
    host.cycle(1'b1, 8'h04, 4'h1, {24'h0, d});
    host.ready();
  endtask
  task automatic dr(input logic [7:0] d);
    rd(8'h04, {24'h0, d}, 32'hff);
    host.ready();
  endtask
  task automatic ac(input logic [6:0] a);
    rd(8'h00, {25'h0, a}, 32'hff);
  endtask
  // Per-line dots: saturates at 48 when both top bits are set
  function automatic logic [23:0] sc_exp(input logic [3:0] h, input logic [5:0] q);
    logic [5:0] v;
    v = (q[5:4] == 2'b11) ? 6'h30 : q;
    sc_exp = {h[3] ? v : 6'h0, h[2] ? v : 6'h0, h[1] ? v : 6'h0, h[0] ? v : 6'h0};
  endfunction
  // Levels seen on the blink outputs over more than two phases
  task automatic watch(output logic [5:0] seen);
    seen = 6'h00;
    repeat (40) begin
      @(posedge clk_i);
      seen = seen | {cfill, ~cfill, cinv, ~cinv, gblink, ~gblink};
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h1f532ceb));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(disp, 1'b0)
    `CHK({gmask, bus8}, 7'h3f)
    `CHK(lmode, cli_pkg::CLI_LINES_TWO)
    `CHK({fw, dshift, sdots}, 32'h0)
    rd(8'h00, 32'h80, 32'hff);
    host.ready();
    rd(8'h08, 32'h0000_04c0, 32'h7fff_ffff);
    for (i = 0; i < 8; i++) begin
      instr(8'h08 | 8'(i));
      rd(8'h08, {29'h0, i[0], i[1], i[2]}, 32'h7);
      `CHK({disp, cshow}, {i[2], i[2] & i[1]})
    end
    watch(hl);
    `CHK(hl, 6'h35)
    instr(8'h0e);
    watch(hl);
    `CHK(hl, 6'h15)
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    instr(8'ha7);
    dw(r1);
    ac(7'h40);
    instr(8'he7);
    dw(r2);
    ac(7'h00);
    instr(8'ha7);
    dr(r1);
    ac(7'h40);
    dr(8'h20);
    instr(8'ha6);
    instr(8'h14);
    ac(7'h27);
    dr(r1);
    instr(8'h10);
    ac(7'h27);
    instr(8'h1c);
    ac(7'h27);
    `CHK(dshift, 7'h01)
    instr(8'h18);
    instr(8'h18);
    `CHK(dshift, 7'h7f)
    instr(8'h04);
    instr(8'h85);
    dw(r2);
    ac(7'h04);
    instr(8'h06);
    g = 8'($urandom_range(62));
    instr(8'h40 | g);
    dw(r1);
    instr(8'h40 | g);
    dr(r1);
    ac(g[6:0] + 7'h01);
    rd(8'h08, 32'h2000_0000, 32'h6000_0000);
    host.cycle(1'b1, 8'h00, 4'h1, 32'h90);
    host.cycle(1'b1, 8'h04, 4'h1, 32'h55);
    host.ready();
    host.cycle(1'b1, 8'h00, 4'h2, 32'hb3);
    ac(7'h10);
    instr(8'h90);
    dr(8'h20);
    rd(8'h0c, 32'h0, 32'hffff_ffff);
    instr(8'h3c);
    rd(8'h08, 32'h100, 32'h300);
    instr(8'h4a);
    dw(r2);
    instr(8'h4a);
    dr(r2);
    rd(8'h08, 32'h4000_0000, 32'h6000_0000);
    for (i = 0; i < 6; i++) begin
      hs = i[0] ? 4'hc : 4'h3;
      sq = (i < 5) ? sq_t[i] : 6'($urandom);
      instr({4'h1, hs});
      instr({2'b10, sq});
      `CHK(sdots, sc_exp(hs, sq))
    end
    instr(8'h0c);
    dw(r1);
    `CHK({fw, gmask, disp}, 8'hff)
    instr(8'h0a);
    `CHK({fw, gmask, cshow}, 8'h3e)
    watch(hl);
    `CHK(hl, 6'h1d)
    instr(8'h3e);
    watch(hl);
    `CHK(hl, 6'h1f)
    instr(8'h09);
    `CHK(lmode, cli_pkg::CLI_LINES_FOUR)
    instr(8'h30);
    rd(8'h08, 32'h20, 32'h120);
    instr(8'h93);
    dw(r1);
    ac(7'h20);
    instr(8'hf3);
    dw(r1);
    ac(7'h00);
    instr(8'h24);
    instr(8'h08);
    instr(8'h20);
    `CHK({bus8, lmode}, {1'b0, cli_pkg::CLI_LINES_ONE})
    instr(8'hcf);
    dw(r2);
    ac(7'h00);
    instr(8'h07);
    dw(r1);
    `CHK(dshift, 7'h7e)
    instr(8'h08);
    instr(8'h80);
    dr(r1);
    instr(8'h02);
    ac(7'h00);
    `CHK(dshift, 7'h00)
    instr(8'h04);
    instr(8'h01);
    rd(8'h08, 32'h400, 32'hc00);
    instr(8'h80);
    dr(8'h20);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({disp, bus8, lmode}, {2'b01, cli_pkg::CLI_LINES_TWO})
    rd(8'h00, 32'h80, 32'hff);
    host.ready();
    results();
  end
endmodule // tb
